// File: hw/fpss_pkg.sv
// constants and decoders for the feedback prescaler and status select block
package fpss_pkg;
    // register map
    localparam int ADDR_W = 10;
    localparam int REG_W = 8;
    localparam logic [9:0] FB_CTRL_ADDR = 10'h016;
    localparam logic [9:0] STATUS_SEL_ADDR = 10'h017;
    localparam logic [7:0] FB_CTRL_RST = 8'h06;
    localparam logic [7:0] STATUS_SEL_RST = 8'h00;
    // field positions
    localparam int BYPASS_BIT = 3;
    localparam int RST_ALL_BIT = 4;
    localparam int RST_AB_BIT = 5;
    localparam int P_LSB = 0;
    localparam int P_W = 3;
    localparam int SEL_LSB = 2;
    localparam int SEL_W = 6;
    // default counter widths
    localparam int A_W = 6;
    localparam int B_W = 13;
    localparam int MOD_W = 6;
    localparam logic [5:0] MOD_MAX = 6'h21;
    // prescaler codes
    localparam logic [2:0] P_FD1 = 3'h0;
    localparam logic [2:0] P_FD2 = 3'h1;
    localparam logic [2:0] P_DM2 = 3'h2;
    localparam logic [2:0] P_DM4 = 3'h3;
    localparam logic [2:0] P_DM8 = 3'h4;
    localparam logic [2:0] P_DM16 = 3'h5;
    localparam logic [2:0] P_DM32 = 3'h6;
    localparam logic [2:0] P_FD3 = 3'h7;
    // status pin selections
    localparam logic [5:0] SEL_GND = 6'h00;
    localparam logic [5:0] SEL_NDIV = 6'h01;
    localparam logic [5:0] SEL_RDIV = 6'h02;
    localparam logic [5:0] SEL_ADIV = 6'h03;
    localparam logic [5:0] SEL_PRE = 6'h04;

    // base divide ratio of a prescaler code
    function automatic logic [5:0] p_base(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h01;
        unique case (code)
            P_FD1: r = 6'h01;
            P_FD2: r = 6'h02;
            P_DM2: r = 6'h02;
            P_DM4: r = 6'h04;
            P_DM8: r = 6'h08;
            P_DM16: r = 6'h10;
            P_DM32: r = 6'h20;
            P_FD3: r = 6'h03;
        endcase
        return r;
    endfunction

    // dual_modulus_mode codes, the rest are fixed_divide_mode
    function automatic logic p_is_dual(input logic [2:0] code);
        return (code >= P_DM2) && (code <= P_DM32);
    endfunction
endpackage

// File: hw/fpss_prescaler.sv
// dual-modulus prescaler counter of the feedback divider
`timescale 1ns/1ns
`default_nettype none
module fpss_prescaler (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic hold_in,
    input wire logic [2:0] code_in,
    input wire logic swallow_in,
    output logic term_out
);
    logic [fpss_pkg::MOD_W-1:0] cnt_reg;
    logic [fpss_pkg::MOD_W-1:0] mod_next;

    // modulus for the cycle about to start, plus one while swallowing in a dual-modulus code
    always_comb begin
        mod_next = fpss_pkg::p_base(code_in);
        if (fpss_pkg::p_is_dual(code_in) && swallow_in) begin
            mod_next = mod_next + 6'h01;
        end
    end

    assign term_out = (cnt_reg == '0);

    // down counter, reloads at terminal count
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else if (ce_in) begin
            if (hold_in || term_out) begin
                cnt_reg <= hold_in ? '0 : mod_next - 6'h01;
            end else begin
                cnt_reg <= cnt_reg - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/fpss_top.sv
// feedback divider control, prescaler mode and status pin selector
`timescale 1ns/1ns
`default_nettype none
module fpss_top #(
    parameter int A_W = fpss_pkg::A_W,
    parameter int B_W = fpss_pkg::B_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [fpss_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [fpss_pkg::REG_W-1:0] reg_wdata_in,
    input wire logic status_lock_in,
    input wire logic [A_W-1:0] swallow_value_in,
    input wire logic [B_W-1:0] b_value_in,
    input wire logic ref_div_in,
    output logic [fpss_pkg::REG_W-1:0] reg_rdata_out,
    output logic fb_div_out,
    output logic status_out
);
    logic [7:0] fb_ctrl_reg;
    logic [7:0] status_sel_reg;
    logic [7:0] rdata_reg;
    logic [A_W-1:0] a_cnt_reg;
    logic [A_W-1:0] a_next;
    logic [B_W-1:0] b_cnt_reg;
    logic [B_W-1:0] b_next;
    logic n_pulse_reg;
    logic n_tog_reg;
    logic a_tog_reg;
    logic p_tog_reg;
    logic status_reg;
    logic status_next;
    logic bypass;
    logic hold_ab;
    logic [2:0] pcode;
    logic [5:0] sel;
    logic pre_term;
    logic n_end;
    logic swallow_next;
    logic wr_fb;
    logic wr_sel;

    // field views of the control registers
    assign bypass = fb_ctrl_reg[fpss_pkg::BYPASS_BIT];
    assign hold_ab = fb_ctrl_reg[fpss_pkg::RST_AB_BIT] | fb_ctrl_reg[fpss_pkg::RST_ALL_BIT];
    assign pcode = fb_ctrl_reg[fpss_pkg::P_LSB +: fpss_pkg::P_W];
    assign sel = status_sel_reg[fpss_pkg::SEL_LSB +: fpss_pkg::SEL_W];
    assign wr_fb = reg_wr_in && (reg_addr_in == fpss_pkg::FB_CTRL_ADDR);
    assign wr_sel = reg_wr_in && (reg_addr_in == fpss_pkg::STATUS_SEL_ADDR);

    // feedback control register, reset puts prescaler at 32/33
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fb_ctrl_reg <= fpss_pkg::FB_CTRL_RST;
        end else if (ce_in && wr_fb) begin
            fb_ctrl_reg <= reg_wdata_in;
        end
    end

    // status select register, selector field ignores writes while locked
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_sel_reg <= fpss_pkg::STATUS_SEL_RST;
        end else if (ce_in && wr_sel) begin
            status_sel_reg[1:0] <= reg_wdata_in[1:0];
            if (!status_lock_in) begin
                status_sel_reg[7:2] <= reg_wdata_in[7:2];
            end
        end
    end

    // read port, unmapped addresses read zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 8'h00;
        end else if (ce_in && reg_rd_in) begin
            unique case (reg_addr_in)
                fpss_pkg::FB_CTRL_ADDR: rdata_reg <= fb_ctrl_reg;
                fpss_pkg::STATUS_SEL_ADDR: rdata_reg <= status_sel_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // end of a feedback cycle; bypass makes every prescaler cycle one
    assign n_end = pre_term && (bypass || (b_cnt_reg <= {{(B_W-1){1'b0}}, 1'b1}));

    // swallow and main counter next values
    always_comb begin
        a_next = a_cnt_reg;
        b_next = b_cnt_reg;
        if (hold_ab) begin
            a_next = swallow_value_in;
            b_next = '0;
        end else if (pre_term) begin
            if (n_end) begin
                a_next = swallow_value_in;
                b_next = b_value_in;
            end else begin
                b_next = b_cnt_reg - {{(B_W-1){1'b0}}, 1'b1};
                if (a_cnt_reg != '0) begin
                    a_next = a_cnt_reg - {{(A_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // swallow is pending for the next prescaler cycle
    assign swallow_next = (a_next != '0);

    fpss_prescaler u_pre (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .hold_in(hold_ab),
        .code_in(pcode),
        .swallow_in(swallow_next),
        .term_out(pre_term)
    );

    // swallow and main counters
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            a_cnt_reg <= '0;
            b_cnt_reg <= '0;
        end else if (ce_in) begin
            a_cnt_reg <= a_next;
            b_cnt_reg <= b_next;
        end
    end

    // divider outputs as pulse and toggling_signal forms
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            n_pulse_reg <= 1'b0;
            n_tog_reg <= 1'b0;
            a_tog_reg <= 1'b0;
            p_tog_reg <= 1'b0;
        end else if (ce_in) begin
            n_pulse_reg <= n_end && !hold_ab;
            if (n_end && !hold_ab) begin
                n_tog_reg <= ~n_tog_reg;
            end
            if (pre_term && !hold_ab && !n_end && (a_cnt_reg == {{(A_W-1){1'b0}}, 1'b1})) begin
                a_tog_reg <= ~a_tog_reg;
            end
            if (pre_term && !hold_ab) begin
                p_tog_reg <= ~p_tog_reg;
            end
        end
    end

    // status pin source selection; unlisted codes give steady_level_signal ground
    always_comb begin
        status_next = 1'b0;
        unique case (sel)
            fpss_pkg::SEL_NDIV: status_next = n_tog_reg;
            fpss_pkg::SEL_RDIV: status_next = ref_div_in;
            fpss_pkg::SEL_ADIV: status_next = a_tog_reg;
            fpss_pkg::SEL_PRE: status_next = p_tog_reg;
            default: status_next = 1'b0;
        endcase
    end

    // registered status pin
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_reg <= 1'b0;
        end else if (ce_in) begin
            status_reg <= status_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign fb_div_out = n_pulse_reg;
    assign status_out = status_reg;

    // checking helpers: length of each prescaler cycle
    logic [5:0] per_cnt_reg;
    logic [2:0] code_start_reg;
    logic sw_start_reg;
    logic per_valid_reg;

    // cycles since last terminal count and mode at its start
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            per_cnt_reg <= 6'h00;
            code_start_reg <= 3'h0;
            sw_start_reg <= 1'b0;
            per_valid_reg <= 1'b0;
        end else if (ce_in) begin
            if (hold_ab) begin
                per_valid_reg <= 1'b0;
                per_cnt_reg <= 6'h00;
            end else if (pre_term) begin
                per_cnt_reg <= 6'h00;
                code_start_reg <= pcode;
                sw_start_reg <= swallow_next && fpss_pkg::p_is_dual(pcode);
                per_valid_reg <= 1'b1;
            end else begin
                per_cnt_reg <= per_cnt_reg + 6'h01;
                if (pcode != code_start_reg) begin
                    per_valid_reg <= 1'b0;
                end
            end
        end
    end

    // a settled prescaler cycle ends here
    logic chk_at_term;
    assign chk_at_term = ce_in && pre_term && !hold_ab && per_valid_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // divide ratio checks at each prescaler terminal count
    chk_bypass_one: assert property (
        ce_in && bypass && !hold_ab && pre_term |=> fb_div_out && $past(p_tog_reg) != p_tog_reg)
        else $error("bypass did not give one feedback pulse per prescaler cycle");
    chk_pre_bound: assert property (
        chk_at_term |-> per_cnt_reg < fpss_pkg::MOD_MAX)
        else $error("prescaler cycle longer than largest ratio");
    chk_fixed_div: assert property (
        chk_at_term && !fpss_pkg::p_is_dual(code_start_reg) |->
        per_cnt_reg == ((code_start_reg == 3'h0) ? 6'h00 : (code_start_reg == 3'h1) ? 6'h01 : 6'h02))
        else $error("fixed divide ratio wrong");
    chk_dm_two: assert property (
        chk_at_term && code_start_reg == 3'h2 |-> per_cnt_reg == (sw_start_reg ? 6'h02 : 6'h01))
        else $error("divide by 2/3 ratio wrong");
    chk_dm_four: assert property (
        chk_at_term && code_start_reg == 3'h3 |-> per_cnt_reg == (sw_start_reg ? 6'h04 : 6'h03))
        else $error("divide by 4/5 ratio wrong");
    chk_dm_eight: assert property (
        chk_at_term && code_start_reg == 3'h4 |-> per_cnt_reg == (sw_start_reg ? 6'h08 : 6'h07))
        else $error("divide by 8/9 ratio wrong");
    chk_dm_sixteen: assert property (
        chk_at_term && code_start_reg == 3'h5 |-> per_cnt_reg == (sw_start_reg ? 6'h10 : 6'h0f))
        else $error("divide by 16/17 ratio wrong");
    chk_dm_thirtytwo: assert property (
        chk_at_term && code_start_reg == 3'h6 |-> per_cnt_reg == (sw_start_reg ? 6'h20 : 6'h1f))
        else $error("divide by 32/33 ratio wrong");

    // reset defaults and selector lock
    chk_reset_mode: assert property (
        $rose(rst_n_in) |-> pcode == 3'h6 && sel == 6'h00 && !status_out)
        else $error("reset defaults wrong");
    chk_sel_locked: assert property (
        ce_in && wr_sel && status_lock_in |=> $stable(sel))
        else $error("selector changed while locked");

    // status pin source checks
    chk_status_ground: assert property (
        ce_in && sel == 6'h00 |=> !status_out)
        else $error("status pin not grounded");
    chk_status_ndiv: assert property (
        ce_in && sel == 6'h01 |=> status_out == $past(n_tog_reg))
        else $error("status pin not feedback divider");
    chk_status_rdiv: assert property (
        ce_in && sel == 6'h02 |=> status_out == $past(ref_div_in))
        else $error("status pin not reference divider");
    chk_status_swpre: assert property (
        ce_in && (sel == 6'h03 || sel == 6'h04) |=>
        status_out == ($past(sel) == 6'h03 ? $past(a_tog_reg) : $past(p_tog_reg)))
        else $error("status pin not swallow or prescaler");
    chk_status_other: assert property (
        ce_in && sel > fpss_pkg::SEL_PRE |=> !status_out)
        else $error("unlisted selection not grounded");

    // register writes and swallow counter run-out
    chk_ctrl_write: assert property (
        ce_in && wr_fb |=> fb_ctrl_reg == $past(reg_wdata_in))
        else $error("control register write lost");
    chk_sel_write: assert property (
        ce_in && wr_sel && !status_lock_in |=> {sel, 2'b00} == ($past(reg_wdata_in) & 8'hfc))
        else $error("selector write lost while unlocked");
    chk_swallow_spent: assert property (
        ce_in && pre_term && !hold_ab && !n_end && a_cnt_reg <= {{(A_W-1){1'b0}}, 1'b1} |-> !swallow_next)
        else $error("swallow kept after swallow counter ran out");

    // main scenarios reached
    cov_bypass: cover property (ce_in && bypass && fb_div_out);
    cov_swallow_cycle: cover property (chk_at_term && sw_start_reg);
    cov_ndiv_toggle: cover property (sel == 6'h01 && $rose(status_out));
    cov_hold_release: cover property (ce_in && $fell(hold_ab));
    cov_locked_write: cover property (ce_in && wr_sel && status_lock_in);
endmodule
`default_nettype wire

// File: verif/feedback_prescaler_status_select_test.sv
// self-checking bench for the feedback prescaler and status select block
`timescale 1ns/1ns
`default_nettype none
module feedback_prescaler_status_select_test;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [9:0] reg_addr_in = 10'h000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic status_lock_in = 1'b0;
    logic [5:0] swallow_value_in = 6'h00;
    logic [12:0] b_value_in = 13'h0003;
    logic ref_div_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic fb_div_out;
    logic status_out;
    int error_cnt = 0;
    int cmp_count = 0;
    int base_tab [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
    int n;
    logic s0;

    fpss_top dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .status_lock_in(status_lock_in), .swallow_value_in(swallow_value_in),
        .b_value_in(b_value_in), .ref_div_in(ref_div_in), .reg_rdata_out(reg_rdata_out),
        .fb_div_out(fb_div_out), .status_out(status_out)
    );

    // 50 mhz clock
    always #10 clk_in = ~clk_in;

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    // one-cycle register read, data checked once settled
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        @(negedge clk_in);
        chk(reg_rdata_out, exp);
    endtask

    // cycles until the next feedback pulse, bounded
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_in);
            cnt++;
        end while (fb_div_out !== 1'b1 && cnt < 300);
        if (cnt >= 300) begin
            chk(8'h01, 8'h00);
        end
    endtask

    // program divider and measure a whole settled period
    task automatic per_chk(input logic [7:0] ctrl, input logic [5:0] a, input int exp);
        swallow_value_in = a;
        wr(fpss_pkg::FB_CTRL_ADDR, ctrl);
        wait_pulse(n);
        wait_pulse(n);
        wait_pulse(n);
        chk(8'(n), 8'(exp));
    endtask

    // status pin must invert between two same-phase points of successive periods
    task automatic tog_chk(input logic [7:0] sel_byte);
        wr(fpss_pkg::STATUS_SEL_ADDR, sel_byte);
        wait_pulse(n);
        wait_pulse(n);
        repeat (3) @(negedge clk_in);
        s0 = status_out;
        wait_pulse(n);
        repeat (3) @(negedge clk_in);
        chk({7'h00, status_out}, {7'h00, ~s0});
    endtask

    // verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hung divider or handshake
    initial begin
        repeat (40000) @(posedge clk_in);
        error_cnt++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        rd_chk(fpss_pkg::FB_CTRL_ADDR, 8'h06);
        rd_chk(fpss_pkg::STATUS_SEL_ADDR, 8'h00);
        chk({7'h00, status_out}, 8'h00);
        wr(10'h018, 8'hff);
        rd_chk(10'h018, 8'h00);
        // every prescaler code with swallow active, b fixed at three
        for (int i = 0; i < 8; i++) begin
            per_chk(8'(i), 6'h02, base_tab[i] * 3 + ((i >= 2 && i <= 6) ? 2 : 0));
        end
        per_chk(8'h03, 6'h00, 12);
        // bypass needs swallow zero
        for (int i = 0; i < 8; i++) begin
            per_chk(8'h08 | 8'(i), 6'h00, base_tab[i]);
        end
        per_chk(8'h06, 6'h02, 98);
        rd_chk(fpss_pkg::FB_CTRL_ADDR, 8'h06);
        // counter hold silences the divider, release restarts it at once
        wr(fpss_pkg::FB_CTRL_ADDR, 8'h26);
        @(negedge clk_in);
        s0 = 1'b0;
        repeat (120) begin
            @(negedge clk_in);
            s0 = s0 | fb_div_out;
        end
        chk({7'h00, s0}, 8'h00);
        wr(fpss_pkg::FB_CTRL_ADDR, 8'h06);
        wait_pulse(n);
        chk(8'(n), 8'h01);
        tog_chk(8'h04);
        tog_chk(8'h0c);
        tog_chk(8'h10);
        // reference divider follows with one cycle latency
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h08);
        for (int k = 0; k < 4; k++) begin
            ref_div_in = k[0] ^ 1'b1;
            @(negedge clk_in);
            chk({7'h00, status_out}, {7'h00, ~k[0]});
        end
        // unlisted and ground selections ignore a high reference
        ref_div_in = 1'b1;
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'hfc);
        @(negedge clk_in);
        chk({7'h00, status_out}, 8'h00);
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h08);
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h00);
        @(negedge clk_in);
        chk({7'h00, status_out}, 8'h00);
        // locked selector keeps upper bits, low bits still written
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h08);
        status_lock_in = 1'b1;
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h07);
        rd_chk(fpss_pkg::STATUS_SEL_ADDR, 8'h0b);
        status_lock_in = 1'b0;
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h04);
        rd_chk(fpss_pkg::STATUS_SEL_ADDR, 8'h04);
        // nothing taken while clock enable is low
        ce_in = 1'b0;
        wr(fpss_pkg::STATUS_SEL_ADDR, 8'h55);
        ce_in = 1'b1;
        rd_chk(fpss_pkg::STATUS_SEL_ADDR, 8'h04);
        give_verdict();
    end
endmodule
`default_nettype wire
